// ### core/vds_core.sv
// video-in downscaler, key compare, status and register file
// ---------------------------------------------------------------
// Notes on behaviour
// RULE1: software loads negative step with destination width
// RULE2: software loads positive step with width difference
// RULE3: horizontal initial error is bits 12:0
// RULE4: vertical initial error is bits 28:16
// RULE5: software loads vertical steps with height values
// RULE6: negative error skips pixel, else emit pixel
// RULE7: negative error drops line at hsync
// RULE8: vertical steps are magnitudes, added or subtracted
// RULE9: refill buffer when free slots reach watermark
// RULE10: watermark value n means n+1 slots
// RULE11: key bounds form an inclusive range
// RULE12: 8-bit index, 24/32-bit blue green red bytes
// RULE13: 15-bit key is 5-5-5 blue green red
// RULE14: 16-bit key is 5-6-5 blue green red
// RULE15: status shows current scan-out line, counting up
// RULE16: status shows last finished buffer, 11 none
// RULE17: status shows last field parity, 1 even
// RULE18: enable cleared then set restarts the processor
// RULE19: screen width 11:0, height 23:12
// RULE20: software sets double width above 1280 pixels
// RULE21: reload errors per line and per field
// ---------------------------------------------------------------
`timescale 1ns/1ps
module vds_core
  import vds_pkg::*;
#(
  parameter int BUF_DW = 32,
  parameter int BUF_DEPTH = 64
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic vid_clk_in,
  input wire logic vid_hsync,
  input wire logic vid_vsync_n,
  input wire logic vid_blank_n,
  input wire logic vid_field_even,
  input wire logic [7:0] vid_data,
  output vds_pix_s pix_out,
  output logic line_keep,
  input wire logic disp_hsync,
  input wire logic disp_vsync,
  input wire logic desk_valid,
  input wire logic [31:0] desk_pix,
  output logic key_hit,
  output logic double_width,
  input wire logic [2:0] buf_wr_en,
  input wire logic [2:0][BUF_DW-1:0] buf_wr_data,
  input wire logic [2:0] buf_rd_en,
  output logic [2:0][BUF_DW-1:0] buf_rd_data,
  output logic [2:0] buf_refill_req
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // channel extract, zero-extended to a byte
  function automatic logic [7:0] chan(input logic [31:0] p,
                                      input int lsb, input int w);
    logic [31:0] m;
    m = (32'h0000_0001 << w) - 32'h0000_0001;
    return 8'((p >> lsb) & m);
  endfunction : chan
  // inclusive range test, equal bounds select one value
  function automatic logic in_rng(input logic [7:0] v,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (v >= lo) && (v <= hi); // RULE11
  endfunction : in_rng
  // per-depth key test across all channels
  function automatic logic key_match(input logic [31:0] p,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi,
                                     input logic [2:0] d);
    logic ok;
    ok = 1'b0;
    case (d)
      DEPTH_8: ok = in_rng(p[7:0], lo[7:0], hi[7:0]); // RULE12
      DEPTH_15: begin // RULE13
        ok = in_rng(chan(p, 0, 5), chan(lo, 0, 5), chan(hi, 0, 5))
          && in_rng(chan(p, K15_G_LSB, 5), chan(lo, K15_G_LSB, 5),
                    chan(hi, K15_G_LSB, 5))
          && in_rng(chan(p, K15_R_LSB, 5), chan(lo, K15_R_LSB, 5),
                    chan(hi, K15_R_LSB, 5));
      end
      DEPTH_16: begin // RULE14
        ok = in_rng(chan(p, 0, 5), chan(lo, 0, 5), chan(hi, 0, 5))
          && in_rng(chan(p, K16_G_LSB, 6), chan(lo, K16_G_LSB, 6),
                    chan(hi, K16_G_LSB, 6))
          && in_rng(chan(p, K16_R_LSB, 5), chan(lo, K16_R_LSB, 5),
                    chan(hi, K16_R_LSB, 5));
      end
      DEPTH_24, DEPTH_32: begin // RULE12
        ok = in_rng(p[7:0], lo[7:0], hi[7:0])
          && in_rng(chan(p, K_G_LSB, 8), chan(lo, K_G_LSB, 8),
                    chan(hi, K_G_LSB, 8))
          && in_rng(chan(p, K_R_LSB, 8), chan(lo, K_R_LSB, 8),
                    chan(hi, K_R_LSB, 8));
      end
      default: ok = 1'b0; // undefined depth never keys
    endcase
    return ok;
  endfunction : key_match
  // sign-extend a 13-bit initial error into the accumulator
  function automatic logic signed [ERR_W:0] sext(
      input logic [ERR_W-1:0] v);
    return {v[ERR_W-1], v};
  endfunction : sext
  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [31:0] cfg_r; // enable, double width, depth
  logic [31:0] fmt_r; // input format select
  logic [31:0] hdel_r; // horizontal steps
  logic [31:0] ierr_r; // initial errors
  logic [31:0] vdel_r; // vertical steps
  logic [31:0] wm_r; // buffer watermarks
  logic [31:0] klo_r; // key lower bound
  logic [31:0] khi_r; // key upper bound
  logic [31:0] scr_r; // screen size
  logic [31:0] status; // status read value
  logic en_prev_r; // enable seen last cycle
  logic restart; // processor restart pulse
  logic vp_rst; // reset of the processor datapath
  logic vmi_mode; // port set to decoder mode
  // software writes, registers take whole words
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_r <= REG_RST;
      fmt_r <= REG_RST;
      hdel_r <= REG_RST;
      ierr_r <= REG_RST;
      vdel_r <= REG_RST;
      wm_r <= REG_RST;
      klo_r <= REG_RST;
      khi_r <= REG_RST;
      scr_r <= REG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_PROC_CFG: cfg_r <= reg_wdata;
        OFS_IN_FMT: fmt_r <= reg_wdata;
        OFS_H_DELTAS: hdel_r <= reg_wdata;
        OFS_INIT_ERRS: ierr_r <= reg_wdata;
        OFS_V_DELTAS: vdel_r <= reg_wdata;
        OFS_WATERMARKS: wm_r <= reg_wdata;
        OFS_KEY_LO: klo_r <= reg_wdata;
        OFS_KEY_HI: khi_r <= reg_wdata;
        OFS_SCREEN: scr_r <= reg_wdata;
        default: ; // status and holes ignore writes
      endcase
    end
  end
  // read mux, one cycle latency, holes read zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_PROC_CFG: reg_rdata <= cfg_r;
        OFS_IN_FMT: reg_rdata <= fmt_r;
        OFS_H_DELTAS: reg_rdata <= hdel_r;
        OFS_INIT_ERRS: reg_rdata <= ierr_r;
        OFS_V_DELTAS: reg_rdata <= vdel_r;
        OFS_WATERMARKS: reg_rdata <= wm_r;
        OFS_KEY_LO: reg_rdata <= klo_r;
        OFS_KEY_HI: reg_rdata <= khi_r;
        OFS_STATUS: reg_rdata <= status;
        OFS_SCREEN: reg_rdata <= {8'h00, scr_r[23:0]}; // RULE19
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0; // data stand for one cycle only
    end
  end
  // enable edge watch: clear then set restarts the processor datapath, not the registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      en_prev_r <= 1'b0;
    end else begin
      en_prev_r <= cfg_r[CFG_EN_BIT];
    end
  end
  assign restart = cfg_r[CFG_EN_BIT] && !en_prev_r; // RULE18
  assign vp_rst = sys_rst || restart; // RULE18
  assign vmi_mode = fmt_r[FMT_LSB +: 2] == FMT_VMI;
  // double width only mirrors software's setting
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      double_width <= 1'b0;
    end else begin
      double_width <= cfg_r[CFG_2X_BIT];
    end
  end
  // ---------------------------------------------------------------
  // decoder port synchronisers and clock edge finder
  // ---------------------------------------------------------------
  vds_vmi_s vmi_raw; // pins as one word
  vds_vmi_s vmi_s1_r; // first stage, read by stage two only
  vds_vmi_s vmi_s2_r; // safe copy
  logic clk_s1_r; // link clock first stage
  logic clk_s2_r; // link clock second stage
  logic clk_s3_r; // link clock one cycle older
  logic vclk_rise; // one-cycle pulse per link rising edge
  assign vmi_raw = '{hsync: vid_hsync, vsync_n: vid_vsync_n,
                     blank_n: vid_blank_n,
                     field_even: vid_field_even, data: vid_data};
  // link clock is 800 ns, so 8 samples per period keep it visible
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vmi_s1_r <= '0;
      vmi_s2_r <= '0;
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
    end else begin
      vmi_s1_r <= vmi_raw;
      vmi_s2_r <= vmi_s1_r;
      clk_s1_r <= vid_clk_in;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
    end
  end
  assign vclk_rise = clk_s2_r && !clk_s3_r;
  // ---------------------------------------------------------------
  // beat sampling and sync edges
  // ---------------------------------------------------------------
  vds_vmi_s beat_r; // value taken at the link edge
  logic beat_v_r; // a new beat is in beat_r
  logic hs_prev_r; // hsync at the last beat
  logic vs_prev_r; // vsync_n at the last beat
  logic line_start; // hsync rising
  logic field_end; // vsync_n falling
  always_ff @(posedge sys_clk) begin
    if (vp_rst) begin
      beat_r <= '{1'b0, 1'b1, 1'b0, 1'b0, 8'h00}; // idle: no false vsync
      beat_v_r <= 1'b0;
      hs_prev_r <= 1'b0;
      vs_prev_r <= 1'b1;
    end else begin
      beat_v_r <= vclk_rise;
      if (vclk_rise) begin
        beat_r <= vmi_s2_r;
        hs_prev_r <= beat_r.hsync;
        vs_prev_r <= beat_r.vsync_n;
      end
    end
  end
  assign line_start = beat_v_r && beat_r.hsync && !hs_prev_r;
  assign field_end = beat_v_r && !beat_r.vsync_n && vs_prev_r;
  // ---------------------------------------------------------------
  // capture sequencer
  // ---------------------------------------------------------------
  vds_cap_e cap_r; // sequencer state
  vds_cap_e cap_nxt; // next state
  always_comb begin
    cap_nxt = cap_r;
    case (cap_r)
      CAP_IDLE: if (cfg_r[CFG_EN_BIT] && vmi_mode) cap_nxt = CAP_WAIT;
      CAP_WAIT: begin // a partial field is never scaled
        if (!cfg_r[CFG_EN_BIT] || !vmi_mode) cap_nxt = CAP_IDLE;
        else if (field_end) cap_nxt = CAP_RUN;
      end
      CAP_RUN: if (!cfg_r[CFG_EN_BIT] || !vmi_mode) cap_nxt = CAP_IDLE;
      default: cap_nxt = CAP_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (vp_rst) begin
      cap_r <= CAP_IDLE;
    end else begin
      cap_r <= cap_nxt;
    end
  end
  // ---------------------------------------------------------------
  // vertical and horizontal error engines
  // ---------------------------------------------------------------
  logic signed [ERR_W:0] verr_r; // vertical accumulator
  logic signed [ERR_W:0] herr_r; // horizontal accumulator
  logic signed [ERR_W:0] v_neg; // vertical step below zero
  logic signed [ERR_W:0] v_pos; // vertical step above zero
  logic signed [ERR_W:0] h_neg; // horizontal step below zero
  logic signed [ERR_W:0] h_pos; // horizontal step above zero
  logic pix_beat; // active pixel beat while capturing
  assign v_neg = {2'b00, vdel_r[NEG_STEP_LSB +: DELTA_W]}; // RULE8
  assign v_pos = {2'b00, vdel_r[POS_STEP_LSB +: DELTA_W]}; // RULE8
  assign h_neg = {2'b00, hdel_r[NEG_STEP_LSB +: DELTA_W]};
  assign h_pos = {2'b00, hdel_r[POS_STEP_LSB +: DELTA_W]};
  assign pix_beat = (cap_r == CAP_RUN) && beat_v_r && beat_r.blank_n
                    && !beat_r.hsync;
  // line decision at each hsync while capturing, reload at field end
  always_ff @(posedge sys_clk) begin
    if (vp_rst) begin
      verr_r <= '0;
      line_keep <= 1'b0;
    end else if (field_end) begin
      verr_r <= sext(ierr_r[V_INIT_LSB +: ERR_W]); // RULE4 RULE21
      line_keep <= 1'b0;
    end else if (line_start && cap_r == CAP_RUN) begin
      if (verr_r < 0) begin // RULE7
        line_keep <= 1'b0;
        verr_r <= verr_r + v_neg;
      end else begin
        line_keep <= 1'b1;
        verr_r <= verr_r - v_pos;
      end
    end
  end
  // pixel decision, error reloaded at each line start
  always_ff @(posedge sys_clk) begin
    if (vp_rst) begin
      herr_r <= '0;
      pix_out <= '0;
    end else begin
      pix_out.valid <= 1'b0;
      if (line_start) begin
        herr_r <= sext(ierr_r[H_INIT_LSB +: ERR_W]); // RULE3 RULE21
      end else if (pix_beat && line_keep) begin
        if (herr_r < 0) begin // RULE6
          herr_r <= herr_r + h_neg;
        end else begin
          pix_out.valid <= 1'b1;
          pix_out.data <= beat_r.data;
          herr_r <= herr_r - h_pos;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // finished buffer, field parity, scan line
  // ---------------------------------------------------------------
  logic [1:0] done_buf_r; // last finished buffer
  logic [1:0] cur_buf_r; // buffer being written
  logic par_r; // parity of last finished field
  logic [LINE_W-1:0] line_r; // scan-out line
  always_ff @(posedge sys_clk) begin
    if (vp_rst) begin
      done_buf_r <= BUF_NONE;
      cur_buf_r <= 2'b00;
      par_r <= 1'b0;
    end else if (field_end && cap_r == CAP_RUN) begin
      done_buf_r <= cur_buf_r; // RULE16
      cur_buf_r <= (cur_buf_r == BUF_LAST) ? 2'b00 : cur_buf_r + 2'b01;
      par_r <= beat_r.field_even; // RULE17
    end
  end
  // counts display lines, vsync wins over hsync
  always_ff @(posedge sys_clk) begin
    if (vp_rst || disp_vsync) begin
      line_r <= '0;
    end else if (disp_hsync) begin
      line_r <= line_r + 1'b1; // RULE15
    end
  end
  assign status = {13'h0000, par_r, done_buf_r, 5'h00, line_r};
  // ---------------------------------------------------------------
  // key compare against the desktop pixel
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      key_hit <= 1'b0;
    end else begin
      key_hit <= desk_valid && key_match(desk_pix, klo_r, khi_r,
                   cfg_r[CFG_DEPTH_LSB +: 3]); // RULE11
    end
  end
  // ---------------------------------------------------------------
  // three pixel buffers
  // ---------------------------------------------------------------
  localparam int WM_LSB [3] = '{WM0_LSB, WM1_LSB, WM2_LSB};
  for (genvar g = 0; g < 3; g++) begin : g_buf
    vds_pix_buf #(.DW(BUF_DW), .DEPTH(BUF_DEPTH)) u_buf (
      .sys_clk(sys_clk),
      .sys_rst(vp_rst),
      .wr_en(buf_wr_en[g]),
      .wr_data(buf_wr_data[g]),
      .rd_en(buf_rd_en[g]),
      .rd_data(buf_rd_data[g]),
      .watermark(wm_r[WM_LSB[g] +: WM_W]), // RULE9
      .refill_req(buf_refill_req[g])
    );
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_keep_beat;
    pix_beat && line_keep && !line_start && !restart;
  endsequence
  a_pix_emit: assert property ((s_keep_beat and (herr_r >= 0)) // RULE6
    |=> pix_out.valid && pix_out.data == $past(beat_r.data))
    else $error("kept pixel not emitted");
  a_pix_skip: assert property ((s_keep_beat and (herr_r < 0)) // RULE6
    |=> !pix_out.valid && herr_r == $past(herr_r) + $past(h_neg))
    else $error("skipped pixel mishandled");
  a_line_drop: assert property (line_start && !field_end // RULE7
    && cap_r == CAP_RUN && verr_r < 0 && !restart |=> !line_keep)
    else $error("line not dropped");
  a_line_step: assert property (line_start && !field_end // RULE8
    && cap_r == CAP_RUN && verr_r >= 0 && !restart
    |=> line_keep && verr_r == $past(verr_r) - $past(v_pos))
    else $error("vertical step wrong");
  a_h_reload: assert property (line_start && !restart // RULE21
    |=> herr_r == sext($past(ierr_r[H_INIT_LSB +: ERR_W])))
    else $error("horizontal error not reloaded");
  a_restart_clr: assert property (restart // RULE18
    |=> done_buf_r == BUF_NONE && cap_r == CAP_IDLE && line_r == '0)
    else $error("restart did not clear");
  a_buf_status: assert property (field_end && cap_r == CAP_RUN // RULE16
    && !restart |=> status[STAT_BUF_LSB +: 2] == $past(cur_buf_r) // RULE16
    && status[STAT_PAR_BIT] == $past(beat_r.field_even)) // RULE17
    else $error("finished buffer status wrong");
  a_line_count: assert property (disp_hsync && !disp_vsync // RULE15
    && !restart |=> line_r == $past(line_r) + 1'b1)
    else $error("scan line not incremented");
  a_read_once: assert property (reg_rd ##1 !reg_rd |=> reg_rdata == '0)
    else $error("read data held too long");
endmodule : vds_core

// ### core/vds_pkg.sv
// constants, types and register map of the video-in downscale block
package vds_pkg;
  // ---------------------------------------------------------------
  // register map, byte offsets on the plain register port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_PROC_CFG = 8'h00; // video_processor_config
  localparam logic [7:0] OFS_IN_FMT = 8'h04; // video_in_format_select
  localparam logic [7:0] OFS_H_DELTAS = 8'h08;
  localparam logic [7:0] OFS_INIT_ERRS = 8'h0C;
  localparam logic [7:0] OFS_V_DELTAS = 8'h10;
  localparam logic [7:0] OFS_WATERMARKS = 8'h14;
  localparam logic [7:0] OFS_KEY_LO = 8'h18;
  localparam logic [7:0] OFS_KEY_HI = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_SCREEN = 8'h24;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_2X_BIT = 1;
  localparam int CFG_DEPTH_LSB = 4;
  localparam int FMT_LSB = 14;
  localparam logic [1:0] FMT_VMI = 2'b01;
  localparam int DELTA_W = 12;
  localparam int NEG_STEP_LSB = 0;
  localparam int POS_STEP_LSB = 16;
  localparam int ERR_W = 13;
  localparam int H_INIT_LSB = 0;
  localparam int V_INIT_LSB = 16;
  localparam int WM_W = 6;
  localparam int WM0_LSB = 0;
  localparam int WM1_LSB = 6;
  localparam int WM2_LSB = 12;
  localparam int LINE_W = 11;
  localparam int STAT_BUF_LSB = 16;
  localparam int STAT_PAR_BIT = 18;
  localparam logic [1:0] BUF_NONE = 2'b11;
  localparam logic [1:0] BUF_LAST = 2'b10;
  localparam int SCR_W_LSB = 0;
  localparam int SCR_H_LSB = 12;
  localparam int SCR_FLD_W = 12;
  // key channel positions for the 15, 16 and 24/32 bit desktops
  localparam int K15_G_LSB = 5;
  localparam int K15_R_LSB = 10;
  localparam int K16_G_LSB = 5;
  localparam int K16_R_LSB = 11;
  localparam int K_G_LSB = 8;
  localparam int K_R_LSB = 16;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DEPTH_8 = 3'd0,
    DEPTH_15 = 3'd1,
    DEPTH_16 = 3'd2,
    DEPTH_24 = 3'd3,
    DEPTH_32 = 3'd4
  } vds_depth_e;
  // capture sequencer, gray along idle -> wait -> capture
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_WAIT = 2'b01,
    CAP_RUN = 2'b11
  } vds_cap_e;
  // one sampled beat of the video decoder port
  typedef struct packed {
    logic hsync;
    logic vsync_n;
    logic blank_n;
    logic field_even;
    logic [7:0] data;
  } vds_vmi_s;
  // one downscaled output pixel
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } vds_pix_s;
endpackage : vds_pkg

// ### core/vds_pix_buf.sv
// one pixel buffer with low-watermark refill request
`timescale 1ns/1ps
module vds_pix_buf
  import vds_pkg::*;
#(
  parameter int DW = 32,
  parameter int DEPTH = 64
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_en,
  output logic [DW-1:0] rd_data,
  input wire logic [WM_W-1:0] watermark,
  output logic refill_req
);
  localparam int AW = $clog2(DEPTH);
  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  logic [DW-1:0] mem_r [DEPTH]; // slot storage
  logic [AW-1:0] wp_r; // write pointer
  logic [AW-1:0] rp_r; // read pointer
  logic [AW:0] used_r; // filled slots
  logic do_wr; // accepted write
  logic do_rd; // accepted read
  logic [AW:0] empty_slots; // free slots
  assign do_wr = wr_en && (used_r != (AW+1)'(DEPTH));
  assign do_rd = rd_en && (used_r != '0);
  assign empty_slots = (AW+1)'(DEPTH) - used_r;
  // memory write, no reset on the array itself
  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem_r[wp_r] <= wr_data;
    end
  end
  // registered read port
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (do_rd) begin
      rd_data <= mem_r[rp_r];
    end
  end
  // pointers and occupancy
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      used_r <= '0;
    end else begin
      if (do_wr) wp_r <= wp_r + 1'b1;
      if (do_rd) rp_r <= rp_r + 1'b1;
      used_r <= used_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
  // field value n stands for n+1 free slots
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      refill_req <= 1'b0;
    end else begin
      refill_req <= empty_slots >= ({1'b0, watermark} + 7'd1); // RULE9 RULE10
    end
  end
endmodule : vds_pix_buf

// ### tb/vds_vmi_model.sv
// video decoder model on the link port
`timescale 1ns/1ps
module vds_vmi_model (
  output logic vid_clk_in,
  output logic vid_hsync,
  output logic vid_vsync_n,
  output logic vid_blank_n,
  output logic vid_field_even,
  output logic [7:0] vid_data
);
  initial {vid_clk_in, vid_hsync, vid_blank_n, vid_field_even} = 4'h0;
  initial {vid_vsync_n, vid_data} = 9'h100;
  // one beat; clock idles between beats, released data toggles
  task automatic beat(input logic hs, vn, bn, input logic [7:0] d);
    vid_hsync <= hs;
    vid_vsync_n <= vn;
    vid_blank_n <= bn;
    vid_data <= bn ? d : ~vid_data;
    #400 vid_clk_in <= 1'b1;
    #400 vid_clk_in <= 1'b0;
  endtask : beat
  // sync beat, n pixels, blank tail
  task automatic line(input int n);
    beat(1, 1, 0, 8'h00);
    for (int i = 0; i < n; i++) beat(0, 1, 1, 8'(i));
    beat(0, 1, 0, 8'h00);
  endtask : line
  // field end with parity
  task automatic fend(input logic ev);
    vid_field_even <= ev;
    beat(0, 0, 0, 8'h00);
    beat(0, 1, 0, 8'h00);
  endtask : fend
endmodule : vds_vmi_model

// ### tb/vds_core_bench.sv
// self-checking bench for the downscale core
`timescale 1ns/1ps
module vds_core_bench;
  import vds_pkg::*;
  logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, dw;
  logic [7:0] reg_addr = 0, vd, lpx = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, desk_pix = 0, r;
  logic disp_hsync = 0, disp_vsync = 0, desk_valid = 0, line_keep, key_hit;
  logic [2:0] wen = 0, ren = 0, req;
  logic [2:0][31:0] bwd = '0, brd;
  logic vc, vh, vv, vb, vf;
  vds_pix_s pix;
  int n_fail = 0, n_tests = 0, n_pix = 0;
  vds_core dut_u (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .vid_clk_in(vc), .vid_hsync(vh),
    .vid_vsync_n(vv), .vid_blank_n(vb), .vid_field_even(vf),
    .vid_data(vd), .pix_out(pix), .line_keep, .disp_hsync,
    .disp_vsync, .desk_valid, .desk_pix, .key_hit,
    .double_width(dw), .buf_wr_en(wen), .buf_wr_data(bwd),
    .buf_rd_en(ren), .buf_rd_data(brd), .buf_refill_req(req));
  vds_vmi_model dec_u (.vid_clk_in(vc), .vid_hsync(vh), .vid_vsync_n(vv),
    .vid_blank_n(vb), .vid_field_even(vf), .vid_data(vd));
  initial forever #50 sys_clk = ~sys_clk;
  // count emitted pixels, keep the last byte
  always @(posedge sys_clk) begin
    if (pix.valid === 1'b1) begin
      n_pix++;
      lpx = pix.data;
    end
  end
  initial begin
    #1ms;
    n_fail++;
    wrap_up;
  end
  task automatic wrap_up;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(string s, logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask : wr
  // data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    @(posedge sys_clk);
    d = reg_rdata; // sampled before this edge clears it
  endtask : rd
  task automatic rc(string s, logic [7:0] a, logic [31:0] e);
    logic [31:0] g;
    rd(a, g);
    chk(s, e, g);
  endtask : rc
  task automatic key(logic [2:0] dp, logic [31:0] lo, hi, p, logic e);
    wr(OFS_PROC_CFG, {25'h000_0000, dp, 4'h1});
    wr(OFS_KEY_LO, lo);
    wr(OFS_KEY_HI, hi);
    @(posedge sys_clk);
    desk_valid <= 1;
    desk_pix <= p;
    @(posedge sys_clk);
    desk_valid <= 0;
    #1 chk("key_hit", 32'(e), 32'(key_hit));
  endtask : key
  initial begin
    int ve, h, ex, lx;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 0;
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rc("status", OFS_STATUS, 32'h0003_0000);
    rc("unmapped", 8'h3C, 32'h0000_0000);
    wr(OFS_WATERMARKS, 32'h0003_E03F);
    rc("wmark", OFS_WATERMARKS, 32'h0003_E03F);
    chk("refill", 32'h0000_0007, 32'(req));
    @(posedge sys_clk);
    wen <= 3'b101;
    bwd[0] <= 32'hA5A5_0F0F;
    @(posedge sys_clk);
    wen <= 3'b000;
    repeat (2) @(posedge sys_clk);
    #1 chk("refill", 32'h0000_0006, 32'(req));
    @(posedge sys_clk);
    ren <= 3'b001;
    @(posedge sys_clk);
    ren <= 3'b000;
    #1 chk("buf_data", 32'hA5A5_0F0F, brd[0]);
    @(posedge sys_clk);
    #1 chk("refill", 32'h0000_0007, 32'(req));
    key(DEPTH_8, 32'h0055, 32'h0055, 32'h0055, 1);
    key(DEPTH_8, 32'h0055, 32'h0055, 32'h0056, 0);
    key(DEPTH_15, 32'h0842, 32'h1084, 32'h0C63, 1);
    key(DEPTH_15, 32'h0842, 32'h1084, 32'h0CA3, 0);
    key(DEPTH_16, 32'h1042, 32'h2084, 32'h1863, 1);
    key(DEPTH_16, 32'h1042, 32'h2084, 32'h18A3, 0);
    key(DEPTH_24, 32'h0020_2020, 32'h0040_4040, 32'h0030_3030, 1);
    key(DEPTH_32, 32'h0020_2020, 32'h0040_4040, 32'h0030_5030, 0);
    wr(OFS_IN_FMT, 32'h0000_4000);
    wr(OFS_H_DELTAS, 32'h0002_0002);
    wr(OFS_INIT_ERRS, 32'h1FFF_1FFF);
    wr(OFS_V_DELTAS, 32'h0001_0001);
    dec_u.fend(1);
    // horizontal walk from -1 over five pixels
    h = -1;
    ex = 0;
    for (int i = 0; i < 5; i++)
      if (h < 0) h += 2;
      else begin
        ex++;
        lx = i;
        h -= 2;
      end
    ve = -1;
    for (int l = 0; l < 3; l++) begin
      h = n_pix;
      dec_u.line(5);
      chk("keep", 32'(ve >= 0), 32'(line_keep));
      chk("pixels", 32'(ve >= 0 ? ex : 0), 32'(n_pix - h));
      if (ve >= 0) chk("pix_data", 32'(lx), 32'(lpx));
      ve = ve < 0 ? ve + 1 : ve - 1;
    end
    dec_u.fend(1);
    rd(OFS_STATUS, r);
    chk("parity", 32'h0000_0001, 32'(r[18]));
    chk("buffer", 32'h0000_0000, 32'(r[17:16]));
    dec_u.fend(0);
    rc("status", OFS_STATUS, 32'h0001_0000);
    wr(OFS_SCREEN, 32'hFF4B_0640);
    rc("screen", OFS_SCREEN, 32'h004B_0640);
    wr(OFS_PROC_CFG, 32'h0000_0000);
    wr(OFS_PROC_CFG, 32'h0000_0003);
    rc("status", OFS_STATUS, 32'h0003_0000);
    chk("dwidth", 32'h0000_0001, 32'(dw));
    repeat (3) begin
      @(posedge sys_clk);
      disp_hsync <= 1;
      @(posedge sys_clk);
      disp_hsync <= 0;
    end
    rc("line", OFS_STATUS, 32'h0003_0003);
    @(posedge sys_clk);
    disp_vsync <= 1;
    @(posedge sys_clk);
    disp_vsync <= 0;
    rc("line", OFS_STATUS, 32'h0003_0000);
    wrap_up;
  end
endmodule : vds_core_bench
